// *** logic/rtc_regs_pkg.sv ***
// control and status register constants for the clock's register file
// assumes a 5-bit register address and 8-bit register data
package rtc_regs_pkg;

   // -----------------------------------------------------------------
   // addresses
   // -----------------------------------------------------------------
   localparam logic [4:0] ADDR_MAIN_STATUS = 5'h00;
   localparam logic [4:0] ADDR_BANK_1 = 5'h01;
   localparam logic [4:0] ADDR_BANK_2 = 5'h02;
   localparam logic [4:0] ADDR_BANK_3 = 5'h03;
   localparam logic [4:0] ADDR_BANK_4 = 5'h04;
   localparam logic [4:0] ADDR_SAVE_FIRST = 5'h19;
   localparam logic [4:0] ADDR_SAVE_LAST = 5'h1D;
   localparam logic [4:0] ADDR_TEST_REG = 5'h1F;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int MS_INT_STATUS = 0;
   localparam int MS_POWER_FAIL_INPUT_N = 1;
   localparam int MS_PERIODIC = 2;
   localparam int MS_ALARM = 3;
   localparam int MS_BLOCK_SEL = 6;
   localparam int PF_OSC_FAIL = 6;
   localparam int PF_TEST = 7;
   localparam int TS_ENABLE = 7;
   localparam int CM_HOUR12 = 2;
   localparam int CM_START = 3;
   localparam int CM_STANDBY_INT = 4;
   localparam int OS_XTAL = 7;
   localparam int IE1_ALARM = 6;
   localparam int IE1_POWER_FAIL_INPUT_N = 7;
   localparam int N_ROLL = 6;
   localparam int SAVE_BYTES = 5;
   localparam int LEAP_W = 2;

   // -----------------------------------------------------------------
   // masks and reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] MS_RAM_MASK = 8'hB0;
   localparam logic [7:0] TS_WRITE_MASK = 8'hBF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [N_ROLL-1:0] ROLL_ZERO = 6'h00;
   localparam logic [LEAP_W-1:0] LEAP_CURRENT = 2'h0;
   localparam logic [LEAP_W-1:0] LEAP_STEP = 2'h1;
   localparam logic RST_OSC_FAIL = 1'b1;
   localparam logic RST_SINGLE_SUPPLY = 1'b1;

   typedef enum logic [3:0] {
      SEL_NONE, SEL_MAIN, SEL_PFLAG, SEL_TSAVE, SEL_CMODE, SEL_OSEL,
      SEL_PIE, SEL_AIE, SEL_SAVE, SEL_TEST
   } reg_sel_t;

endpackage

// *** logic/rollover_if.sv ***
// rollover events and periodic flag state shared by the register file
// assumes one clock domain; the flag keeper drives flags and hit
`timescale 1ns/1ps
interface rollover_if;
   logic [rtc_regs_pkg::N_ROLL-1:0] rollover;
   logic [rtc_regs_pkg::N_ROLL-1:0] enable;
   logic rd_clear;
   logic [rtc_regs_pkg::N_ROLL-1:0] flags;
   logic periodic_hit;
   modport flags_side (input rollover, input enable, input rd_clear,
      output flags, output periodic_hit);
   modport regs_side (output rollover, output enable, output rd_clear,
      input flags, input periodic_hit);
endinterface

// *** logic/periodic_flags.sv ***
// periodic rollover flags, cleared by a read, and the enabled-hit term
// assumes rollover bits are one-cycle pulses in the sys_clk domain
`timescale 1ns/1ps
module periodic_flags
   import rtc_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   rollover_if.flags_side rif
);

   logic [N_ROLL-1:0] flags_q;

   // -----------------------------------------------------------------
   // flags
   // -----------------------------------------------------------------
   // a rollover in the reading cycle survives the clear
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_q <= ROLL_ZERO;
      end else if (rif.rd_clear) begin
         flags_q <= rif.rollover;
      end else begin
         flags_q <= flags_q | rif.rollover;
      end
   end

   assign rif.flags = flags_q;
   // no enabled bit, no periodic hit
   assign rif.periodic_hit = |(rif.rollover & rif.enable);

endmodule

// *** logic/rtc_ctrl_regs.sv ***
// control and status register file of the real-time clock
// assumes synchronous inputs, one-cycle event pulses, and a master that
// never asserts read and write strobes together
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps

module rtc_ctrl_regs
   import rtc_regs_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [N_ROLL-1:0] rollover_evt,
   input wire logic alarm_evt,
   input wire logic osc_fail_evt,
   input wire logic osc_running,
   input wire logic power_fail_input_n,
   input wire logic standby_entry,
   input wire logic dec31_evt,
   input wire logic xtal_level,
   input wire logic [SAVE_BYTES*8-1:0] clock_counters,
   output logic interrupt_request_pin,
   output logic multifunction_output,
   output logic clock_run,
   output logic hour12_mode,
   output logic [LEAP_W-1:0] leap_count,
   output logic feb29_enable,
   output logic single_supply,
   output logic test_mode_en
);

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   function automatic reg_sel_t reg_decode(input logic [4:0] addr, input logic bs);
      reg_sel_t s;
      s = SEL_NONE;
      if (addr == ADDR_MAIN_STATUS) begin
         s = SEL_MAIN;
      end else if (addr == ADDR_BANK_1) begin
         s = bs ? SEL_CMODE : SEL_NONE;
      end else if (addr == ADDR_BANK_2) begin
         s = bs ? SEL_OSEL : SEL_NONE;
      end else if (addr == ADDR_BANK_3) begin
         s = bs ? SEL_PIE : SEL_PFLAG;
      end else if (addr == ADDR_BANK_4) begin
         s = bs ? SEL_AIE : SEL_TSAVE;
      end else if (addr >= ADDR_SAVE_FIRST && addr <= ADDR_SAVE_LAST) begin
         s = SEL_SAVE;
      end else if (addr == ADDR_TEST_REG) begin
         s = SEL_TEST;
      end
      return s;
   endfunction

   reg_sel_t sel;
   logic wr_main, wr_pflag, wr_tsave, wr_cmode, wr_osel, wr_pie, wr_aie;
   logic wr_save, wr_test, standby_clr;
   logic [2:0] save_idx;

   logic block_sel_q;
   logic [7:0] ms_ram_q;
   logic stat_pf_q, stat_per_q, stat_alarm_q, int_stat_q;
   logic osc_fail_q;
   logic [7:0] tsave_q;
   logic [7:0] cmode_q;
   logic [7:0] osel_q;
   logic [7:0] pie_q;
   logic [7:0] aie_q;
   logic [7:0] test_reg_q;
   logic [SAVE_BYTES-1:0][7:0] save_q;
   logic [LEAP_W-1:0] leap_d;
   logic [7:0] rdata_d;
   logic interrupt_request_pin_d, mfo_int_d;

   rollover_if rif ();

   periodic_flags periodic_flags_i (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .rif(rif)
   );

   always_comb begin
      sel = reg_decode(reg_addr, block_sel_q);
      wr_main = reg_wr && sel == SEL_MAIN;
      wr_pflag = reg_wr && sel == SEL_PFLAG;
      wr_tsave = reg_wr && sel == SEL_TSAVE;
      wr_cmode = reg_wr && sel == SEL_CMODE;
      wr_osel = reg_wr && sel == SEL_OSEL;
      wr_pie = reg_wr && sel == SEL_PIE;
      wr_aie = reg_wr && sel == SEL_AIE;
      wr_save = reg_wr && sel == SEL_SAVE;
      wr_test = reg_wr && sel == SEL_TEST;
      save_idx = 3'(reg_addr - ADDR_SAVE_FIRST);
      standby_clr = standby_entry && !cmode_q[CM_STANDBY_INT];
   end

   assign rif.rollover = rollover_evt;
   assign rif.enable = pie_q[N_ROLL-1:0];
   assign rif.rd_clear = reg_rd && sel == SEL_PFLAG;

   // -----------------------------------------------------------------
   // main status
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         block_sel_q <= 1'b0;
         ms_ram_q <= BYTE_ZERO;
      end else if (wr_main) begin
         block_sel_q <= reg_wdata[MS_BLOCK_SEL];
         ms_ram_q <= reg_wdata & MS_RAM_MASK;
      end
   end

   // pin level, not a write, owns this bit
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_pf_q <= 1'b0;
      end else begin
         stat_pf_q <= !power_fail_input_n;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_alarm_q <= 1'b0;
      end else if (alarm_evt) begin
         stat_alarm_q <= 1'b1;
      end else if (wr_main && reg_wdata[MS_ALARM]) begin
         stat_alarm_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat_per_q <= 1'b0;
      end else if (standby_clr) begin
         stat_per_q <= 1'b0;
      end else if (rif.periodic_hit) begin
         stat_per_q <= 1'b1;
      end else if (wr_main && reg_wdata[MS_PERIODIC]) begin
         stat_per_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // interrupt outputs
   // -----------------------------------------------------------------
   always_comb begin
      interrupt_request_pin_d = (stat_alarm_q && aie_q[IE1_ALARM]) || stat_per_q
         || (stat_pf_q && aie_q[IE1_POWER_FAIL_INPUT_N]);
      mfo_int_d = stat_pf_q && aie_q[IE1_POWER_FAIL_INPUT_N];
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         interrupt_request_pin <= 1'b0;
         multifunction_output <= 1'b0;
         int_stat_q <= 1'b0;
      end else begin
         interrupt_request_pin <= interrupt_request_pin_d;
         multifunction_output <= osel_q[OS_XTAL] ? xtal_level : mfo_int_d;
         // mirrors the interrupt pin, and the multifunction pin outside xtal mode, so it drops once the status bits are gone
         int_stat_q <= interrupt_request_pin
            || (multifunction_output && !osel_q[OS_XTAL]);
      end
   end

   // -----------------------------------------------------------------
   // periodic flag register bits six and seven, and the test register
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         osc_fail_q <= RST_OSC_FAIL;
      end else if (osc_fail_evt) begin
         osc_fail_q <= 1'b1;
      end else if (wr_cmode && reg_wdata[CM_START] && osc_running) begin
         osc_fail_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         single_supply <= RST_SINGLE_SUPPLY;
         test_mode_en <= 1'b0;
      end else begin
         if (osc_fail_evt) begin
            single_supply <= 1'b1;
         end else if (wr_pflag) begin
            single_supply <= reg_wdata[PF_OSC_FAIL];
         end
         if (wr_pflag) begin
            test_mode_en <= reg_wdata[PF_TEST];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         test_reg_q <= BYTE_ZERO;
      end else if (wr_test) begin
         test_reg_q <= reg_wdata;
      end
   end

   // -----------------------------------------------------------------
   // time save
   // -----------------------------------------------------------------
   // switchover clears the enable, so the last tracked time stays held
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tsave_q <= BYTE_ZERO;
      end else if (standby_entry) begin
         tsave_q <= tsave_q & ~(8'h01 << TS_ENABLE);
      end else if (wr_tsave) begin
         tsave_q <= reg_wdata & TS_WRITE_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         save_q <= '0;
      end else if (tsave_q[TS_ENABLE]) begin
         save_q <= clock_counters;
      end else if (wr_save) begin
         save_q[save_idx] <= reg_wdata;
      end
   end

   // -----------------------------------------------------------------
   // clock mode
   // -----------------------------------------------------------------
   always_comb begin
      leap_d = cmode_q[LEAP_W-1:0];
      if (wr_cmode) begin
         leap_d = reg_wdata[LEAP_W-1:0];
      end else if (dec31_evt) begin
         leap_d = cmode_q[LEAP_W-1:0] + LEAP_STEP;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmode_q <= BYTE_ZERO;
      end else begin
         if (wr_cmode) begin
            cmode_q[7:LEAP_W] <= reg_wdata[7:LEAP_W];
         end
         cmode_q[LEAP_W-1:0] <= leap_d;
         // an oscillator not yet running keeps the chain stopped
         if (osc_fail_evt || !osc_running) begin
            cmode_q[CM_START] <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         clock_run <= 1'b0;
         hour12_mode <= 1'b0;
         leap_count <= LEAP_CURRENT;
         feb29_enable <= 1'b1;
      end else begin
         clock_run <= wr_cmode ? reg_wdata[CM_START] && osc_running && !osc_fail_evt
            : cmode_q[CM_START] && osc_running && !osc_fail_evt;
         hour12_mode <= wr_cmode ? reg_wdata[CM_HOUR12] : cmode_q[CM_HOUR12];
         leap_count <= leap_d;
         feb29_enable <= leap_d == LEAP_CURRENT;
      end
   end

   // -----------------------------------------------------------------
   // output select and interrupt controls
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         osel_q <= BYTE_ZERO;
      end else if (wr_osel) begin
         osel_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pie_q <= BYTE_ZERO;
         aie_q <= BYTE_ZERO;
      end else if (standby_clr) begin
         pie_q <= BYTE_ZERO;
         aie_q <= BYTE_ZERO;
      end else begin
         if (wr_pie) begin
            pie_q <= reg_wdata;
         end
         if (wr_aie) begin
            aie_q <= reg_wdata;
         end
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   always_comb begin
      rdata_d = BYTE_ZERO;
      if (reg_rd) begin
         case (sel)
            SEL_MAIN: begin
               rdata_d = ms_ram_q;
               rdata_d[MS_BLOCK_SEL] = block_sel_q;
               rdata_d[MS_ALARM] = stat_alarm_q;
               rdata_d[MS_PERIODIC] = stat_per_q;
               rdata_d[MS_POWER_FAIL_INPUT_N] = stat_pf_q;
               rdata_d[MS_INT_STATUS] = int_stat_q;
            end
            SEL_PFLAG: begin
               rdata_d[N_ROLL-1:0] = rif.flags;
               rdata_d[PF_OSC_FAIL] = osc_fail_q;
               rdata_d[PF_TEST] = test_mode_en;
            end
            SEL_TSAVE: rdata_d = tsave_q;
            SEL_CMODE: rdata_d = cmode_q;
            SEL_OSEL: rdata_d = osel_q;
            SEL_PIE: rdata_d = pie_q;
            SEL_AIE: rdata_d = aie_q;
            SEL_SAVE: rdata_d = save_q[save_idx];
            SEL_TEST: rdata_d = test_reg_q;
            default: rdata_d = BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= BYTE_ZERO;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_flag_read;
      reg_rd && sel == SEL_PFLAG && rollover_evt == ROLL_ZERO;
   endsequence

   sequence s_flags_zero;
      rif.flags == ROLL_ZERO;
   endsequence

   a_main_any_block: assert property (
      reg_rd && reg_addr == ADDR_MAIN_STATUS |=> reg_rdata[MS_BLOCK_SEL] == $past(block_sel_q))
      else $error("main status not decoded at address zero");
   a_int_status_drops: assert property (
      (!stat_alarm_q && !stat_per_q && !stat_pf_q)[*2] |=> !int_stat_q)
      else $error("interrupt status stuck after status cleared");
   a_alarm_w1c: assert property (
      wr_main && reg_wdata[MS_ALARM] && !alarm_evt |=> !stat_alarm_q)
      else $error("alarm status not cleared by written one");
   a_power_fail_input_n_clears: assert property (
      power_fail_input_n |=> !stat_pf_q)
      else $error("power-fail status not cleared by high pin");
   a_alarm_unmasked: assert property (
      alarm_evt && !aie_q[IE1_ALARM] |=> stat_alarm_q)
      else $error("masked alarm did not set status");
   a_flags_read_clr: assert property (
      s_flag_read |=> s_flags_zero)
      else $error("periodic flags survived a read");
   a_osc_fail_force: assert property (
      osc_fail_evt |=> osc_fail_q && single_supply && !clock_run)
      else $error("oscillator fail did not force flags");
   a_start_held: assert property (
      !osc_running |=> !clock_run ##1 !cmode_q[CM_START] || osc_running)
      else $error("clock ran without oscillator");
   a_save_frozen: assert property (
      !tsave_q[TS_ENABLE] && !wr_save |=> $stable(save_q))
      else $error("saved time changed while frozen");
   a_standby_clear: assert property (
      standby_clr |=> pie_q == BYTE_ZERO && !stat_per_q && !tsave_q[TS_ENABLE])
      else $error("standby did not clear controls");
   a_leap_step: assert property (
      dec31_evt && !wr_cmode |=> leap_count == $past(cmode_q[LEAP_W-1:0]) + LEAP_STEP)
      else $error("leap counter did not step");
   a_no_periodic: assert property (
      pie_q[N_ROLL-1:0] == ROLL_ZERO && !wr_main && !standby_clr && !stat_per_q |=> !stat_per_q)
      else $error("periodic status set with no enables");

endmodule

// *** verif/host_master.sv ***
// host side of the register bus: single-byte writes and reads
// assumes the block answers a read in the cycle after the strobe, never stalls
`timescale 1ns/1ps
module host_master (
   input wire logic sys_clk,
   input wire logic [7:0] reg_rdata,
   output logic [4:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end

   // -------------------------------
   // bus cycles
   // -------------------------------
   // released lines take inverted values so nothing stale looks valid
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(posedge sys_clk);
      v = reg_rdata;
   endtask

   // battery-backed mode, test mode off; block select is zero after power-up
   task automatic init();
      wr(5'h03, 8'h00);
   endtask
endmodule

// *** verif/rtc_ctrl_regs_tb_top.sv ***
// self-checking bench for the control and status register file
// assumes host_master speaks the register bus; events are bench pulses
`timescale 1ns/1ps
module rtc_ctrl_regs_tb_top
   import rtc_regs_pkg::*;
();
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, alarm_evt, osc_fail_evt, osc_running, power_fail_input_n;
   logic standby_entry, dec31_evt, xtal_level, interrupt_request_pin;
   logic multifunction_output, clock_run, hour12_mode, feb29_enable;
   logic single_supply, test_mode_en;
   logic [N_ROLL-1:0] rollover_evt;
   logic [SAVE_BYTES*8-1:0] clock_counters;
   logic [LEAP_W-1:0] leap_count;
   int n_mismatch = 0;
   int samples_checked = 0;
   // packed view of the output levels, compared as one byte
   wire [7:0] outs = {multifunction_output, interrupt_request_pin, hour12_mode,
      leap_count, feb29_enable, single_supply, clock_run};

   always #2.5 sys_clk = ~sys_clk;

   rtc_ctrl_regs rtc_ctrl_regs_i (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .rollover_evt, .alarm_evt, .osc_fail_evt, .osc_running,
      .power_fail_input_n, .standby_entry, .dec31_evt, .xtal_level, .clock_counters,
      .interrupt_request_pin, .multifunction_output, .clock_run, .hour12_mode,
      .leap_count, .feb29_enable, .single_supply, .test_mode_en);

   host_master host_master_i (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd);

   // -------------------------------
   // helpers
   // -------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      host_master_i.wr(a, v);
   endtask

   task automatic rdc(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] v;
      host_master_i.rd(a, v);
      chk(v, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic end_sim();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // the whole sequence is a few hundred cycles
   initial begin
      #50000;
      n_mismatch++;
      end_sim();
   end

   // -------------------------------
   // tests
   // -------------------------------
   initial begin
      {alarm_evt, osc_fail_evt, standby_entry, dec31_evt, xtal_level} = 5'h00;
      {osc_running, power_fail_input_n} = 2'h3;
      rollover_evt = 6'h00;
      clock_counters = 40'h0504030201;
      idle(10);
      rst_b <= 1'b1;
      chk(outs, 8'h06);
      rdc(5'h00, 8'h00);
      rdc(5'h03, 8'h40);
      host_master_i.init();
      idle(2);
      chk(outs, 8'h04);
      rdc(5'h03, 8'h40);
      @(posedge sys_clk) rollover_evt <= 6'h24;
      @(posedge sys_clk) rollover_evt <= 6'h00;
      rdc(5'h03, 8'h64);
      rdc(5'h03, 8'h40);
      rdc(5'h00, 8'h00);
      wr(5'h00, 8'hF0);
      rdc(5'h00, 8'hF0);
      wr(5'h00, 8'h40);
      wr(5'h01, 8'h0F);
      idle(2);
      chk(outs, 8'h39);
      @(posedge sys_clk) dec31_evt <= 1'b1;
      @(posedge sys_clk) dec31_evt <= 1'b0;
      idle(2);
      chk(outs, 8'h25);
      rdc(5'h01, 8'h0C);
      wr(5'h00, 8'h00);
      rdc(5'h03, 8'h00);
      rdc(5'h01, 8'h00);
      wr(5'h00, 8'h40);
      wr(5'h03, 8'h04);
      @(posedge sys_clk) rollover_evt <= 6'h04;
      @(posedge sys_clk) rollover_evt <= 6'h00;
      idle(3);
      rdc(5'h00, 8'h45);
      chk(outs, 8'h65);
      rdc(5'h00, 8'h45);
      wr(5'h00, 8'h44);
      idle(3);
      rdc(5'h00, 8'h40);
      chk(outs, 8'h25);
      @(posedge sys_clk) rollover_evt <= 6'h01;
      @(posedge sys_clk) rollover_evt <= 6'h00;
      idle(3);
      rdc(5'h00, 8'h40);
      @(posedge sys_clk) alarm_evt <= 1'b1;
      @(posedge sys_clk) alarm_evt <= 1'b0;
      idle(3);
      rdc(5'h00, 8'h48);
      wr(5'h00, 8'h48);
      rdc(5'h00, 8'h40);
      power_fail_input_n <= 1'b0;
      idle(3);
      rdc(5'h00, 8'h42);
      wr(5'h00, 8'h42);
      rdc(5'h00, 8'h42);
      power_fail_input_n <= 1'b1;
      idle(3);
      rdc(5'h00, 8'h40);
      wr(5'h02, 8'h80);
      xtal_level <= 1'b1;
      idle(3);
      chk(outs, 8'hA5);
      xtal_level <= 1'b0;
      idle(3);
      chk(outs, 8'h25);
      @(posedge sys_clk) osc_fail_evt <= 1'b1;
      @(posedge sys_clk) osc_fail_evt <= 1'b0;
      idle(2);
      chk(outs, 8'h26);
      rdc(5'h01, 8'h04);
      osc_running <= 1'b0;
      wr(5'h01, 8'h0C);
      idle(2);
      chk(outs, 8'h26);
      osc_running <= 1'b1;
      wr(5'h01, 8'h0C);
      idle(2);
      chk(outs, 8'h27);
      wr(5'h02, 8'h00);
      wr(5'h04, 8'hC0);
      power_fail_input_n <= 1'b0;
      idle(4);
      chk(outs, 8'hE7);
      rdc(5'h00, 8'h43);
      power_fail_input_n <= 1'b1;
      idle(4);
      rdc(5'h00, 8'h40);
      @(posedge sys_clk) alarm_evt <= 1'b1;
      @(posedge sys_clk) alarm_evt <= 1'b0;
      idle(3);
      chk(outs, 8'h67);
      rdc(5'h00, 8'h49);
      wr(5'h00, 8'h48);
      idle(3);
      rdc(5'h00, 8'h40);
      wr(5'h01, 8'h1C);
      @(posedge sys_clk) standby_entry <= 1'b1;
      @(posedge sys_clk) standby_entry <= 1'b0;
      rdc(5'h03, 8'h04);
      rdc(5'h04, 8'hC0);
      wr(5'h01, 8'h0C);
      @(posedge sys_clk) standby_entry <= 1'b1;
      @(posedge sys_clk) standby_entry <= 1'b0;
      rdc(5'h03, 8'h00);
      wr(5'h00, 8'h00);
      rdc(5'h03, 8'h05);
      wr(5'h04, 8'hFF);
      rdc(5'h04, 8'hBF);
      rdc(5'h19, 8'h01);
      wr(5'h04, 8'h3F);
      clock_counters <= 40'h0A0A0A0A0A;
      rdc(5'h19, 8'h01);
      wr(5'h04, 8'hBF);
      rdc(5'h1A, 8'h0A);
      @(posedge sys_clk) standby_entry <= 1'b1;
      @(posedge sys_clk) standby_entry <= 1'b0;
      rdc(5'h04, 8'h3F);
      wr(5'h03, 8'h80);
      idle(2);
      chk(8'(test_mode_en), 8'h01);
      wr(5'h1F, 8'h5A);
      rdc(5'h1F, 8'h5A);
      wr(5'h1F, 8'h00);
      wr(5'h03, 8'h00);
      idle(2);
      chk(8'(test_mode_en), 8'h00);
      end_sim();
   end
endmodule
